// *** hw/spcr_map.svh ***
`ifndef SPCR_MAP_SVH
`define SPCR_MAP_SVH
`define SPCR_NPORT        4
`define SPCR_IDX_CTRL1    8'h01
`define SPCR_IDX_THR_HI   8'h02
`define SPCR_IDX_THR_LO   8'h03
`define SPCR_IDX_CTRL2    8'h09
`define SPCR_IDX_CTRL3    8'h0b
`define SPCR_IDX_CTRL4    8'h0d
`define SPCR_IDX_PRE_DIV  8'h0e
`define SPCR_IDX_LOOP_DIV 8'h10
`define SPCR_IDX_CLK_MUX  8'h12
`define SPCR_IDX_CSEL12   8'h13
`define SPCR_IDX_CSEL34   8'h14
`define SPCR_IDX_MODE     8'h2b
`define SPCR_CTRL1_WMASK  8'h7d
`define SPCR_CTRLN_WMASK  8'h75
`define SPCR_CTRL_RST     8'h00
`define SPCR_PRE_DIV_RST  6'h03
`define SPCR_LOOP_DIV_RST 6'h08
`define SPCR_MODE_RST     8'hc4
`define SPCR_MODE_IRDA    7
`define SPCR_STAT_SHORT   4'h5
`define SPCR_STAT_LONG    4'hd
`define SPCR_BANK_BYTES   512
`endif

// *** hw/spcr_pkg.sv ***
package spcr_pkg;
    typedef struct packed {
        logic rsv7;
        logic fsm_rx_guard;
        logic rx_disable;
        logic rx_invert;
        logic drv_ready;
        logic cts_delta_report_en;
        logic rsv1;
        logic hw_flow_ctl_en;
    } spcr_ctrl_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] index;
        logic [7:0] wdata;
    } spcr_req_t;

    typedef enum logic [2:0] {
        SPCR_SRC_STD_BAUD,
        SPCR_SRC_30M,
        SPCR_SRC_96M,
        SPCR_SRC_120M,
        SPCR_SRC_PLL,
        SPCR_SRC_EXTERNAL_CLOCK_IN,
        SPCR_SRC_RSV6,
        SPCR_SRC_RSV7
    } spcr_clk_src_t;
endpackage

// *** hw/spcr_regs.sv ***
`timescale 1ns/1ps
`include "spcr_map.svh"
module spcr_regs
    import spcr_pkg::*;
#(
    parameter int BANK_BYTES = `SPCR_BANK_BYTES
)
(
    input  wire logic                clk,
    input  wire logic                nrst,
    input  wire logic                ce,
    input  wire spcr_req_t           req,
    input  wire logic [7:0]          mode_straps,
    input  wire logic [3:0]          cts_n,
    input  wire logic [3:0]          cts_delta_clr,
    input  wire logic [3:0]          rxd_in,
    input  wire logic [3:0]          tx_busy,
    input  wire logic [3:0]          rx_byte_wr,
    input  wire logic [3:0]          bulk_in_req,
    output logic                     rd_valid,
    output logic [7:0]               rd_data,
    output logic [3:0]               hw_flow_ctl_en,
    output logic [3:0]               cts_delta,
    output logic                     ram_for_serial,
    output logic [3:0]               rxd_out,
    output logic [3:0]               rx_accept,
    output logic [3:0]               bank_sel,
    output logic [3:0]               bank_full,
    output logic [3:0]               bulk_ack,
    output logic [3:0]               bulk_nak,
    output logic [3:0][9:0]          bulk_len,
    output logic [5:0]               pll_pre_div,
    output logic [5:0]               pll_loop_div,
    output logic [1:0]               pll_src,
    output logic                     pll_out_band,
    output logic [3:0]               status_len,
    output spcr_clk_src_t [3:0]      port_clk_src
);
    // Register storage
    spcr_ctrl_t  ctrl_q [4];
    logic [7:0]  thr_hi_q;
    logic [6:0]  thr_lo_q;
    logic [5:0]  pre_q;
    logic [5:0]  loop_q;
    logic [3:0]  mux_q;
    logic [5:0]  csel_q [2];
    logic [7:0]  mode_q;
    logic        mode_cap_q;
    logic        rd_valid_q;
    logic [7:0]  rd_data_q;
    logic [7:0]  rd_mux;
    logic [14:0] thr_w;
    logic        irda;
    logic        wr_hit;
    logic [2:0]  wr_ctrl;
    // Per-port state
    logic        cts_prev_q [4];
    logic        delta_q    [4];
    logic        rxd_q      [4];
    logic        acc_q      [4];
    logic        bank_q     [4];
    logic        full_q     [4];
    logic        ack_q      [4];
    logic        nak_q      [4];
    logic [9:0]  len_q      [4];
    logic [9:0]  fill_q     [4];
    logic [9:0]  held_q     [4];
    logic [14:0] timer_q    [4];
    // Config outputs
    logic [3:0]    flow_q;
    logic          ram_q;
    logic [5:0]    pre_out_q;
    logic [5:0]    loop_out_q;
    logic [1:0]    src_q;
    logic          band_q;
    logic [3:0]    stat_q;
    spcr_clk_src_t psrc_q [4];
    // Maps a control register index to {hit, port}
    function automatic logic [2:0] ctrl_hit(input logic [7:0] idx);
        case (idx)
            `SPCR_IDX_CTRL1: return 3'h4;
            `SPCR_IDX_CTRL2: return 3'h5;
            `SPCR_IDX_CTRL3: return 3'h6;
            `SPCR_IDX_CTRL4: return 3'h7;
            default:         return 3'h0;
        endcase
    endfunction
    assign thr_w   = {thr_hi_q, thr_lo_q};
    assign irda    = mode_q[`SPCR_MODE_IRDA];
    assign wr_hit  = ce && req.valid && req.write;
    assign wr_ctrl = ctrl_hit(req.index);
    // Control registers; reserved bits never store
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < 4; i++)
                ctrl_q[i] <= `SPCR_CTRL_RST;
        end
        else if (wr_hit && wr_ctrl[2])
        begin
            if (wr_ctrl[1:0] == 2'h0)
                ctrl_q[0] <= req.wdata & `SPCR_CTRL1_WMASK;
            else
                ctrl_q[wr_ctrl[1:0]] <= req.wdata & `SPCR_CTRLN_WMASK;
        end
    end
    // Shared threshold, PLL and clock selection registers
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            thr_hi_q  <= 8'h00;
            thr_lo_q  <= 7'h00;
            pre_q     <= `SPCR_PRE_DIV_RST;
            loop_q    <= `SPCR_LOOP_DIV_RST;
            mux_q     <= 4'h0;
            csel_q[0] <= 6'h00;
            csel_q[1] <= 6'h00;
        end
        else if (wr_hit)
        begin
            case (req.index)
                `SPCR_IDX_THR_HI:   thr_hi_q  <= req.wdata;
                `SPCR_IDX_THR_LO:   thr_lo_q  <= req.wdata[6:0];
                `SPCR_IDX_PRE_DIV:  pre_q     <= req.wdata[5:0];
                `SPCR_IDX_LOOP_DIV: loop_q    <= req.wdata[5:0];
                `SPCR_IDX_CLK_MUX:  mux_q     <= req.wdata[3:0];
                `SPCR_IDX_CSEL12:   csel_q[0] <= req.wdata[5:0];
                `SPCR_IDX_CSEL34:   csel_q[1] <= req.wdata[5:0];
                default:            ;
            endcase
        end
    end
    // Bond straps caught once after reset release, then frozen
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            mode_q     <= `SPCR_MODE_RST;
            mode_cap_q <= 1'b0;
        end
        else if (ce && !mode_cap_q)
        begin
            mode_q     <= mode_straps;
            mode_cap_q <= 1'b1;
        end
    end
    // Read mux; unmapped indices read zero
    always_comb
    begin
        rd_mux = 8'h00;
        if (wr_ctrl[2])
            rd_mux = ctrl_q[wr_ctrl[1:0]];
        else
        begin
            case (req.index)
                `SPCR_IDX_THR_HI:   rd_mux = thr_hi_q;
                `SPCR_IDX_THR_LO:   rd_mux = {1'b0, thr_lo_q};
                `SPCR_IDX_PRE_DIV:  rd_mux = {2'b00, pre_q};
                `SPCR_IDX_LOOP_DIV: rd_mux = {2'b00, loop_q};
                `SPCR_IDX_CLK_MUX:  rd_mux = {4'h0, mux_q};
                `SPCR_IDX_CSEL12:   rd_mux = {2'b00, csel_q[0]};
                `SPCR_IDX_CSEL34:   rd_mux = {2'b00, csel_q[1]};
                `SPCR_IDX_MODE:     rd_mux = mode_q;
                default:            rd_mux = 8'h00;
            endcase
        end
    end
    // Read answer one cycle after the request
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            rd_valid_q <= 1'b0;
            rd_data_q  <= 8'h00;
        end
        else if (ce)
        begin
            rd_valid_q <= req.valid && !req.write;
            if (req.valid && !req.write)
                rd_data_q <= rd_mux;
        end
    end
    // Configuration fan-out to UARTs and PLL
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            flow_q     <= 4'h0;
            ram_q      <= 1'b0;
            pre_out_q  <= `SPCR_PRE_DIV_RST;
            loop_out_q <= `SPCR_LOOP_DIV_RST;
            src_q      <= 2'b00;
            band_q     <= 1'b0;
            stat_q     <= `SPCR_STAT_SHORT;
        end
        else if (ce)
        begin
            for (int i = 0; i < 4; i++)
                flow_q[i] <= ctrl_q[i].hw_flow_ctl_en;
            ram_q      <= ctrl_q[0].drv_ready;
            pre_out_q  <= pre_q;
            loop_out_q <= loop_q;
            src_q      <= mux_q[1:0];
            band_q     <= mux_q[2];
            stat_q     <= mux_q[3] ? `SPCR_STAT_LONG
                                   : `SPCR_STAT_SHORT;
        end
    end
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_port
            logic wr;
            logic tmo;
            // Bytes only land while memories belong to serial data
            assign wr  = rx_byte_wr[g] && acc_q[g] && ctrl_q[0].drv_ready;
            assign tmo = (thr_w != 15'h0) && (fill_q[g] != 10'h0)
                         && (held_q[g] == 10'h0)
                         && (15'(timer_q[g] + 15'h1) >= thr_w);
            // Port clock source from odd-low / even-high fields
            always_ff @(posedge clk)
            begin
                if (!nrst)
                    psrc_q[g] <= SPCR_SRC_STD_BAUD;
                else if (ce)
                    psrc_q[g] <= spcr_clk_src_t'(
                        csel_q[g/2][(g%2)*3 +: 3]);
            end
            // Delta CTS: a change while clearing still sets
            always_ff @(posedge clk)
            begin
                if (!nrst)
                begin
                    cts_prev_q[g] <= 1'b1;
                    delta_q[g]    <= 1'b0;
                end
                else if (ce)
                begin
                    cts_prev_q[g] <= cts_n[g];
                    if (ctrl_q[g].cts_delta_report_en
                        && cts_n[g] != cts_prev_q[g])
                        delta_q[g] <= 1'b1;
                    else if (cts_delta_clr[g])
                        delta_q[g] <= 1'b0;
                end
            end
            // Receive qualifiers depend on infrared mode
            always_ff @(posedge clk)
            begin
                if (!nrst)
                begin
                    rxd_q[g] <= 1'b1;
                    acc_q[g] <= 1'b0;
                end
                else if (ce)
                begin
                    rxd_q[g] <= rxd_in[g]
                        ^ (irda && ctrl_q[g].rx_invert);
                    if (irda)
                        acc_q[g] <= !(ctrl_q[g].fsm_rx_guard
                                      && tx_busy[g]);
                    else
                        acc_q[g] <= !ctrl_q[g].rx_disable;
                end
            end
            // Two-bank Bulk-In bookkeeping; host read wins over timeout
            always_ff @(posedge clk)
            begin
                if (!nrst)
                begin
                    bank_q[g]  <= 1'b0;
                    fill_q[g]  <= 10'h000;
                    held_q[g]  <= 10'h000;
                    timer_q[g] <= 15'h0000;
                    ack_q[g]   <= 1'b0;
                    nak_q[g]   <= 1'b0;
                    len_q[g]   <= 10'h000;
                    full_q[g]  <= 1'b0;
                end
                else if (ce)
                begin
                    ack_q[g]  <= 1'b0;
                    nak_q[g]  <= 1'b0;
                    full_q[g] <= (fill_q[g] == 10'(BANK_BYTES));
                    if (bulk_in_req[g] && held_q[g] != 10'h000)
                    begin
                        ack_q[g]  <= 1'b1;
                        len_q[g]  <= held_q[g];
                        held_q[g] <= 10'h000;
                        if (wr && fill_q[g] != 10'(BANK_BYTES))
                            fill_q[g] <= 10'(fill_q[g] + 10'h001);
                    end
                    else if (bulk_in_req[g] && fill_q[g] != 10'h000)
                    begin
                        ack_q[g]   <= 1'b1;
                        len_q[g]   <= fill_q[g];
                        bank_q[g]  <= !bank_q[g];
                        fill_q[g]  <= {9'h000, wr};
                        timer_q[g] <= 15'h0000;
                    end
                    else if (bulk_in_req[g])
                    begin
                        nak_q[g] <= 1'b1;
                        fill_q[g] <= {9'h000, wr};
                    end
                    else if (tmo)
                    begin
                        held_q[g]  <= fill_q[g];
                        bank_q[g]  <= !bank_q[g];
                        fill_q[g]  <= {9'h000, wr};
                        timer_q[g] <= 15'h0000;
                    end
                    else
                    begin
                        if (wr && fill_q[g] != 10'(BANK_BYTES))
                            fill_q[g] <= 10'(fill_q[g] + 10'h001);
                        if (fill_q[g] == 10'h000)
                            timer_q[g] <= 15'h0000;
                        else if (timer_q[g] != 15'h7fff)
                            timer_q[g] <= 15'(timer_q[g] + 15'h1);
                    end
                end
            end
            assign cts_delta[g]    = delta_q[g];
            assign rxd_out[g]      = rxd_q[g];
            assign rx_accept[g]    = acc_q[g];
            assign bank_sel[g]     = bank_q[g];
            assign bank_full[g]    = full_q[g];
            assign bulk_ack[g]     = ack_q[g];
            assign bulk_nak[g]     = nak_q[g];
            assign bulk_len[g]     = len_q[g];
            assign port_clk_src[g] = psrc_q[g];
        end
    endgenerate
    assign rd_valid       = rd_valid_q;
    assign rd_data        = rd_data_q;
    assign hw_flow_ctl_en = flow_q;
    assign ram_for_serial = ram_q;
    assign pll_pre_div    = pre_out_q;
    assign pll_loop_div   = loop_out_q;
    assign pll_src        = src_q;
    assign pll_out_band   = band_q;
    assign status_len     = stat_q;
    // Checks on port 1 paths, plus the port 2 bit 3 mask and threshold low readback
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_empty_req;
        ce && bulk_in_req[0] && fill_q[0] == 10'h0 && held_q[0] == 10'h0;
    endsequence
    sequence s_data_req;
        ce && bulk_in_req[0] && held_q[0] == 10'h0 && fill_q[0] != 10'h0;
    endsequence
    chk_flow_follow:
        assert property (ce && ctrl_q[0].hw_flow_ctl_en |=> hw_flow_ctl_en[0])
        else $error("flow control not applied");
    chk_cts_quiet:
        assert property (ce && !ctrl_q[0].cts_delta_report_en
                         && !cts_delta[0] |=> !cts_delta[0])
        else $error("delta cts set while disabled");
    chk_cts_set:
        assert property (ce && ctrl_q[0].cts_delta_report_en
                         && cts_n[0] != cts_prev_q[0] |=> cts_delta[0])
        else $error("delta cts missed");
    chk_bit3_rsv:
        assert property (wr_hit && wr_ctrl == 3'h5 |=> !ctrl_q[1].drv_ready)
        else $error("port 2 bit 3 stored");
    chk_ram_desc:
        assert property (ce && !ctrl_q[0].drv_ready && fill_q[0] == 10'h0
                         && !bulk_in_req[0] |=> fill_q[0] == 10'h0)
        else $error("serial data before driver ready");
    chk_rx_invert:
        assert property (ce && irda && ctrl_q[0].rx_invert
                         |=> rxd_out[0] == !$past(rxd_in[0]))
        else $error("irda receive not inverted");
    chk_rx_disable:
        assert property (ce && !irda && ctrl_q[0].rx_disable |=> !rx_accept[0])
        else $error("disabled port accepts data");
    chk_rx_echo:
        assert property (ce && irda && ctrl_q[0].fsm_rx_guard && tx_busy[0]
                         |=> !rx_accept[0])
        else $error("receive during own transmit");
    chk_nak_empty:
        assert property (s_empty_req |=> bulk_nak[0] && !bulk_ack[0])
        else $error("empty request not refused");
    chk_bank_swap:
        assert property (s_data_req |=> bulk_ack[0]
                         && bank_sel[0] != $past(bank_sel[0]))
        else $error("bank not switched on read");
    chk_lo_bit7:
        assert property (ce && req.valid && !req.write
                         && req.index == `SPCR_IDX_THR_LO
                         |=> rd_valid && !rd_data[7])
        else $error("threshold low bit 7 not zero");
endmodule

// *** verif/spcr_host_model.sv ***
`timescale 1ns/1ps
`include "spcr_map.svh"
module spcr_host_model
    import spcr_pkg::*;
(
    input  wire logic       clk,
    output spcr_req_t       req,
    input  wire logic       rd_valid,
    input  wire logic [7:0] rd_data
);
    initial req = '0;

    // Request raised after an edge, dropped on the edge that takes it
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        // A zero divisor would stall the clock, so it is never sent
        if ((idx == `SPCR_IDX_PRE_DIV || idx == `SPCR_IDX_LOOP_DIV)
            && d[5:0] == 6'h00)
            return;
        @(posedge clk);
        req <= '{valid: 1'b1, write: 1'b1, index: idx, wdata: d};
        @(posedge clk);
        req <= '0;
    endtask

    // Read answer looked for on a bounded number of cycles
    task automatic rd(input  logic [7:0] idx,
                      output logic [7:0] d,
                      output logic       ok);
        ok = 1'b0;
        d = 8'h00;
        @(posedge clk);
        req <= '{valid: 1'b1, write: 1'b0, index: idx, wdata: 8'h00};
        @(posedge clk);
        req <= '0;
        for (int i = 0; i < 4 && !ok; i++)
        begin
            @(negedge clk);
            if (rd_valid === 1'b1)
            begin
                ok = 1'b1;
                d = rd_data;
            end
        end
    endtask
endmodule

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`include "spcr_map.svh"
module tb_top
    import spcr_pkg::*;
();
    logic                clk = 1'b0;
    logic                nrst = 1'b0;
    logic                ce = 1'b1;
    spcr_req_t           req;
    logic [7:0]          mode_straps = `SPCR_MODE_RST;
    logic [3:0]          cts_n = 4'hf;
    logic [3:0]          cts_delta_clr = 4'h0;
    logic [3:0]          rxd_in = 4'hf;
    logic [3:0]          tx_busy = 4'h0;
    logic [3:0]          rx_byte_wr = 4'h0;
    logic [3:0]          bulk_in_req = 4'h0;
    logic                rd_valid, ram_for_serial, pll_out_band;
    logic [7:0]          rd_data;
    logic [3:0]          hw_flow_ctl_en, cts_delta, rxd_out, rx_accept;
    logic [3:0]          bank_sel, bank_full, bulk_ack, bulk_nak, status_len;
    logic [3:0][9:0]     bulk_len;
    logic [5:0]          pll_pre_div, pll_loop_div;
    logic [1:0]          pll_src;
    spcr_clk_src_t [3:0] port_clk_src;
    int                  num_errors = 0;
    int                  samples_checked = 0;

    always #4 clk = ~clk;

    spcr_regs #(.BANK_BYTES(512)) spcr_regs_inst (
        .clk(clk), .nrst(nrst), .ce(ce), .req(req),
        .mode_straps(mode_straps), .cts_n(cts_n),
        .cts_delta_clr(cts_delta_clr), .rxd_in(rxd_in),
        .tx_busy(tx_busy), .rx_byte_wr(rx_byte_wr),
        .bulk_in_req(bulk_in_req), .rd_valid(rd_valid),
        .rd_data(rd_data), .hw_flow_ctl_en(hw_flow_ctl_en),
        .cts_delta(cts_delta), .ram_for_serial(ram_for_serial),
        .rxd_out(rxd_out), .rx_accept(rx_accept), .bank_sel(bank_sel),
        .bank_full(bank_full), .bulk_ack(bulk_ack), .bulk_nak(bulk_nak),
        .bulk_len(bulk_len), .pll_pre_div(pll_pre_div),
        .pll_loop_div(pll_loop_div), .pll_src(pll_src),
        .pll_out_band(pll_out_band), .status_len(status_len),
        .port_clk_src(port_clk_src));

    spcr_host_model spcr_host_model_inst (
        .clk(clk), .req(req), .rd_valid(rd_valid), .rd_data(rd_data));

    task automatic print_verdict();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] exp,
                       input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        spcr_host_model_inst.wr(idx, d);
        repeat (2) @(negedge clk);
    endtask

    // A missing read answer ends the run at once
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        spcr_host_model_inst.rd(idx, d, ok);
        chk("rd_valid", 1'b1, ok);
        if (!ok)
            print_verdict();
        else
            chk("rd_data", exp, d);
    endtask

    task automatic bulk(input int p, input logic ack, input logic [9:0] n);
        @(posedge clk) bulk_in_req <= 4'h1 << p;
        @(posedge clk) bulk_in_req <= 4'h0;
        @(negedge clk);
        chk("bulk_ack", ack, bulk_ack[p]);
        chk("bulk_nak", !ack, bulk_nak[p]);
        if (ack)
            chk("bulk_len", n, bulk_len[p]);
    endtask

    task automatic bytes_in(input int p, input int n);
        repeat (n) @(posedge clk) rx_byte_wr <= 4'h1 << p;
        @(posedge clk) rx_byte_wr <= 4'h0;
    endtask

    // Reset values, write masks, unmapped and read-only places
    task automatic t_regs();
        logic [7:0] ix [12] = '{8'h01, 8'h02, 8'h03, 8'h09, 8'h0b, 8'h0d,
                                8'h0e, 8'h10, 8'h12, 8'h13, 8'h14, 8'h2b};
        logic [7:0] rv [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                8'h03, 8'h08, 8'h00, 8'h00, 8'h00, 8'hc4};
        logic [7:0] mk [12] = '{8'h7d, 8'hff, 8'h7f, 8'h75, 8'h75, 8'h75,
                                8'h02, 8'h3f, 8'h0f, 8'h3f, 8'h3f, 8'hc4};
        for (int i = 0; i < 12; i++)
            rdchk(ix[i], rv[i]);
        // Port 1 first, so driver-ready precedes port setup
        // Pre-divisor of 2 keeps 12 MHz over it inside the legal band
        for (int i = 0; i < 12; i++)
            wr(ix[i], ix[i] == `SPCR_IDX_PRE_DIV ? 8'hc2 : 8'hff);
        for (int i = 0; i < 12; i++)
            rdchk(ix[i], mk[i]);
        wr(8'h07, 8'hff);
        rdchk(8'h07, 8'h00);
        chk("pll_pre_div", 6'h02, pll_pre_div);
        chk("pll_loop_div", 6'h3f, pll_loop_div);
        chk("pll_src", 2'h3, pll_src);
        chk("pll_out_band", 1'b1, pll_out_band);
        chk("status_len", `SPCR_STAT_LONG, status_len);
        chk("hw_flow_ctl_en", 4'hf, hw_flow_ctl_en);
        wr(`SPCR_IDX_CLK_MUX, 8'h01);
        chk("pll_src", 2'h1, pll_src);
        chk("status_len", `SPCR_STAT_SHORT, status_len);
        wr(`SPCR_IDX_THR_HI, 8'h00);
        wr(`SPCR_IDX_THR_LO, 8'h00);
    endtask

    // Source codes 0 to 5 on every port, fields sharing a register kept distinct
    task automatic t_clksrc();
        for (int c = 0; c < 6; c++)
        begin
            wr(`SPCR_IDX_CSEL12, 8'((5 - c) << 3 | c));
            wr(`SPCR_IDX_CSEL34, 8'(c << 3 | (5 - c)));
            chk("port1_src", c, port_clk_src[0]);
            chk("port2_src", 5 - c, port_clk_src[1]);
            chk("port3_src", 5 - c, port_clk_src[2]);
            chk("port4_src", c, port_clk_src[3]);
        end
    endtask

    // Control bits per port, strapped infrared mode
    task automatic t_ctrl();
        wr(`SPCR_IDX_CTRL1, 8'h4c);
        wr(`SPCR_IDX_CTRL2, 8'h10);
        wr(`SPCR_IDX_CTRL3, 8'h01);
        wr(`SPCR_IDX_CTRL4, 8'h60);
        chk("ram_for_serial", 1'b1, ram_for_serial);
        chk("hw_flow_ctl_en", 4'h4, hw_flow_ctl_en);
        @(posedge clk) cts_n <= 4'he;
        @(posedge clk) tx_busy <= 4'h9;
        rxd_in <= 4'hd;
        repeat (4) @(negedge clk);
        chk("cts_delta", 1'b1, cts_delta[0]);
        chk("rxd_out", 1'b1, rxd_out[1]);
        chk("rx_accept", 4'h6, rx_accept);
        @(posedge clk) tx_busy <= 4'h0;
        rxd_in <= 4'hf;
        cts_delta_clr <= 4'h1;
        @(posedge clk) cts_delta_clr <= 4'h0;
        wr(`SPCR_IDX_CTRL1, 8'h08);
        @(posedge clk) cts_n <= 4'hf;
        repeat (4) @(negedge clk);
        chk("cts_delta", 1'b0, cts_delta[0]);
        chk("rxd_out", 1'b0, rxd_out[1]);
        chk("rx_accept", 4'hf, rx_accept);
        wr(`SPCR_IDX_CTRL4, 8'h00);
    endtask

    task automatic t_bulk();
        logic b;
        bulk(3, 1'b0, 10'd0);
        bytes_in(0, 3);
        b = bank_sel[0];
        bulk(0, 1'b1, 10'd3);
        chk("bank_sel", !b, bank_sel[0]);
        bulk(0, 1'b0, 10'd0);
        // Overfill port 3: bank caps at 512, extra bytes dropped
        bytes_in(2, 520);
        @(negedge clk);
        chk("bank_full", 4'h4, bank_full);
        bulk(2, 1'b1, 10'd512);
    endtask

    // Shared threshold of 128 cycles times high plus low
    task automatic t_timeout();
        logic b;
        int   n;
        wr(`SPCR_IDX_THR_HI, 8'h01);
        bytes_in(1, 1);
        b = bank_sel[1];
        for (n = 0; n < 200 && bank_sel[1] === b; n++)
            @(negedge clk);
        chk("swap_window", 1'b1, n >= 124 && n <= 134);
        chk("bank_sel_after_wait", !b, bank_sel[1]);
        bulk(1, 1'b1, 10'd1);
        wr(`SPCR_IDX_THR_HI, 8'h00);
    endtask

    // Straps without infrared: bits 4 and 6 idle, bit 5 blocks receive
    task automatic t_noirda();
        @(posedge clk) nrst <= 1'b0;
        mode_straps <= 8'h44;
        tx_busy <= 4'h4;
        rxd_in <= 4'hd;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rdchk(`SPCR_IDX_MODE, 8'h44);
        // Bytes before driver-ready must not reach the bank
        bytes_in(0, 1);
        bulk(0, 1'b0, 10'd0);
        chk("ram_for_serial", 1'b0, ram_for_serial);
        wr(`SPCR_IDX_CTRL1, 8'h08);
        wr(`SPCR_IDX_CTRL2, 8'h30);
        wr(`SPCR_IDX_CTRL3, 8'h40);
        chk("rx_accept", 4'hd, rx_accept);
        chk("rxd_out", 1'b0, rxd_out[1]);
    endtask

    initial
    begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        chk("status_len_rst", `SPCR_STAT_SHORT, status_len);
        chk("pll_pre_div_rst", `SPCR_PRE_DIV_RST, pll_pre_div);
        chk("pll_loop_div_rst", `SPCR_LOOP_DIV_RST, pll_loop_div);
        t_regs();
        t_clksrc();
        t_ctrl();
        t_bulk();
        t_timeout();
        t_noirda();
        print_verdict();
    end
endmodule
